//--- adc_serial_readout.sv
// device side of the serial converter readout: frame control, data shift,
// track-and-hold and power-down state.
// assumes cs_n and sclk come from the host, unrelated to clk (sampled here).
// Summary of operation
// - cs fall: hold, sample unless powered down, drive output, convert
// - sixteen serial clocks complete one conversion
// - after edge 13, track on next rise
// - edge 16 falling releases the output
// - early cs rise aborts, output released
// - cs fall gives first zero; falls shift
// - last bit driven on fifteenth falling edge
// - cs rise edges 2..9 enters power-down
// - frame past edge ten powers up
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout #(
  parameter int RES = adc_readout_pkg::RESULT_BITS
) (
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic           cs_n,
  input  wire logic           sclk,
  input  wire logic [RES-1:0] sample_value,
  output logic                serial_out,
  output logic                serial_oe,
  output logic                hold,
  output logic                powered_down,
  output logic                sample_strobe
);
  // three-flop synchronisers; only stage two and later are read
  logic [2:0] cs_sync;
  logic [2:0] sclk_sync;
  logic cs_fall;
  logic cs_rise;
  logic sc_fall;
  logic sc_rise;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cs_sync   <= 3'h7;
      sclk_sync <= 3'h7;
    end else begin
      cs_sync   <= {cs_sync[1:0], cs_n};
      sclk_sync <= {sclk_sync[1:0], sclk};
    end
  end

  assign cs_fall = cs_sync[2] & ~cs_sync[1];
  assign cs_rise = ~cs_sync[2] & cs_sync[1];
  assign sc_fall = sclk_sync[2] & ~sclk_sync[1];
  assign sc_rise = ~sclk_sync[2] & sclk_sync[1];

  adc_readout_pkg::frame_state_t state;
  adc_readout_pkg::frame_state_t next_state;
  logic [4:0]  edges;
  logic [4:0]  next_edges;
  logic [15:0] shreg;
  logic [15:0] next_shreg;
  logic        next_out;
  logic        next_oe;
  logic        next_hold;
  logic        next_pd;
  logic        next_strobe;
  logic        track_pending;
  logic        next_track_pending;

  // frame word: leading zeros, then result msb first in the low bits; no trailing padding when RES is 12
  function automatic logic [15:0] frame_word(input logic [RES-1:0] v);
    logic [15:0] w;
    w = 16'h0000;
    w[15-adc_readout_pkg::LEAD_ZEROS -: RES] = v;
    return w;
  endfunction : frame_word

  always_comb begin
    next_state         = state;
    next_edges         = edges;
    next_shreg         = shreg;
    next_out           = serial_out;
    next_oe            = serial_oe;
    next_hold          = hold;
    next_pd            = powered_down;
    next_strobe        = 1'b0;
    next_track_pending = track_pending;
    case (state)
      adc_readout_pkg::IDLE: begin
        if (cs_fall) begin
          next_state  = adc_readout_pkg::SHIFT;
          next_edges  = adc_readout_pkg::CNT_ZERO;
          next_shreg  = frame_word(sample_value);
          next_hold   = 1'b1;
          next_oe     = 1'b1;
          next_out    = 1'b0;
          next_strobe = ~powered_down;
        end
      end
      adc_readout_pkg::SHIFT: begin
        if (cs_rise) begin
          next_state = adc_readout_pkg::IDLE;
          next_oe    = 1'b0;
          next_out   = 1'b0;
          next_track_pending = 1'b0;
          if (powered_down) begin
            if (edges < 5'(adc_readout_pkg::PD_EDGE_HI))
              next_pd = 1'b1;
          end else if (edges >= 5'(adc_readout_pkg::PD_EDGE_LO) &&
                       edges < 5'(adc_readout_pkg::PD_EDGE_HI)) begin
            next_pd = 1'b1;
          end
          if (next_pd)
            next_hold = 1'b1;
        end else begin
          // waking from power-down, the first link edge returns to track;
          // with an idle-high clock that first edge is a fall
          if (powered_down && (sc_rise || sc_fall) &&
              edges == adc_readout_pkg::CNT_ZERO)
            next_hold = 1'b0;
          if (sc_fall) begin
            next_edges = edges + 5'h01;
            next_shreg = {shreg[14:0], 1'b0};
            next_out   = shreg[14];
            if (edges == 5'(adc_readout_pkg::PD_EDGE_HI - 1))
              next_pd = 1'b0;
            if (edges == 5'(adc_readout_pkg::TRACK_EDGE - 1))
              next_track_pending = 1'b1;
            if (edges == 5'(adc_readout_pkg::FRAME_BITS - 1)) begin
              next_oe    = 1'b0;
              next_out   = 1'b0;
              next_state = adc_readout_pkg::DONE;
            end
          end
          if (sc_rise && track_pending) begin
            next_hold          = 1'b0;
            next_track_pending = 1'b0;
          end
        end
      end
      adc_readout_pkg::DONE: begin
        if (sc_rise && track_pending) begin
          next_hold          = 1'b0;
          next_track_pending = 1'b0;
        end
        if (cs_rise)
          next_state = adc_readout_pkg::IDLE;
      end
      default: next_state = adc_readout_pkg::IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state         <= adc_readout_pkg::IDLE;
      edges         <= 5'h00;
      shreg         <= 16'h0000;
      serial_out    <= 1'b0;
      serial_oe     <= 1'b0;
      hold          <= 1'b0;
      powered_down  <= 1'b0;
      sample_strobe <= 1'b0;
      track_pending <= 1'b0;
    end else begin
      state         <= next_state;
      edges         <= next_edges;
      shreg         <= next_shreg;
      serial_out    <= next_out;
      serial_oe     <= next_oe;
      hold          <= next_hold;
      powered_down  <= next_pd;
      sample_strobe <= next_strobe;
      track_pending <= next_track_pending;
    end
  end

  // checks
  a_drive_on_cs: assert property (@(posedge clk) disable iff (!rstn)
    state == adc_readout_pkg::IDLE && cs_fall |=> serial_oe && hold
      && serial_out == 1'b0)
    else $error("cs fall did not start frame");
  a_release_16: assert property (@(posedge clk) disable iff (!rstn)
    state == adc_readout_pkg::SHIFT && !cs_rise && sc_fall
      && edges == 5'h0F |=> !serial_oe)
    else $error("output not released at edge 16");
  a_abort_release: assert property (@(posedge clk) disable iff (!rstn)
    state == adc_readout_pkg::SHIFT && cs_rise |=> !serial_oe
      && state == adc_readout_pkg::IDLE)
    else $error("early cs rise not aborted");
  a_shift_bit: assert property (@(posedge clk) disable iff (!rstn)
    state == adc_readout_pkg::SHIFT && !cs_rise && sc_fall
      && edges < 5'h0F |=> serial_out == $past(shreg[14]))
    else $error("wrong bit shifted");
  a_lead_zeros: assert property (@(posedge clk) disable iff (!rstn)
    serial_oe && edges < 5'h04 |-> serial_out == 1'b0)
    else $error("leading zero violated");
  a_track_13: assert property (@(posedge clk) disable iff (!rstn)
    track_pending && sc_rise && state != adc_readout_pkg::IDLE |=> !hold)
    else $error("no return to track");
  a_last_bit: assert property (@(posedge clk) disable iff (!rstn)
    state == adc_readout_pkg::SHIFT && !cs_rise && sc_fall
      && edges == 5'h0E |=> serial_oe && edges == 5'h0F)
    else $error("last bit not driven at edge 15");
  a_pd_enter: assert property (@(posedge clk) disable iff (!rstn)
    state == adc_readout_pkg::SHIFT && cs_rise && !powered_down
      && edges >= 5'h02 && edges < 5'h0A |=> powered_down)
    else $error("power-down not entered");
  a_pd_keep: assert property (@(posedge clk) disable iff (!rstn)
    state == adc_readout_pkg::SHIFT && cs_rise && edges < 5'h02
      && !powered_down |=> !powered_down)
    else $error("glitch powered down");
  a_pd_exit: assert property (@(posedge clk) disable iff (!rstn)
    powered_down && state == adc_readout_pkg::SHIFT && !cs_rise && sc_fall
      && edges == 5'h09 |=> !powered_down)
    else $error("power-up not reached");
  a_wake_track: assert property (@(posedge clk) disable iff (!rstn)
    powered_down && state == adc_readout_pkg::SHIFT && !cs_rise && sc_fall
      && edges == 5'h00 |=> !hold)
    else $error("no track on first edge after wake");
  c_full_frame: cover property (@(posedge clk) disable iff (!rstn)
    state == adc_readout_pkg::SHIFT ##1 state == adc_readout_pkg::DONE);
  c_abort: cover property (@(posedge clk) disable iff (!rstn)
    state == adc_readout_pkg::SHIFT && cs_rise && edges > 5'h0A);
  c_pd_enter: cover property (@(posedge clk) disable iff (!rstn)
    !powered_down ##1 powered_down);
  c_pd_exit: cover property (@(posedge clk) disable iff (!rstn)
    powered_down ##1 !powered_down);
endmodule : adc_serial_readout
`default_nettype wire

//--- adc_readout_pkg.sv
// package for the serial converter readout block
// assumes a single clock domain; link pins are sampled by the block itself
package adc_readout_pkg;
  localparam int FRAME_BITS     = 16;
  localparam int LEAD_ZEROS     = 4;
  localparam int TRACK_EDGE     = 13;
  localparam int PD_EDGE_LO     = 2;
  localparam int PD_EDGE_HI     = 10;
  localparam int RESULT_BITS    = 12;
  localparam logic [4:0] CNT_ZERO = 5'h00;

  typedef enum logic [1:0] {
    IDLE,
    SHIFT,
    DONE
  } frame_state_t;

  typedef struct packed {
    logic out;
    logic oe;
  } serial_pin_t;
endpackage : adc_readout_pkg

//--- host_model.sv
// host side model: frames cs_n, idle-high sclk, gathers the data bits
// assumes the device answers each link edge within a 24 ns half period
`timescale 1ns/1ps
`default_nettype none
module host_model (
  output logic        cs_n,
  output logic        sclk,
  input  wire logic   serial_out,
  input  wire logic   serial_oe,
  output logic [15:0] word,
  output logic [15:0] word_rise
);
  logic pin;
  logic last;
  int   falls;
  // a released line shows the inverse of the last driven bit, so a host
  // sampling after release never reads a good value by luck
  always @* begin
    if (serial_oe) last = serial_out;
  end
  assign pin = serial_oe ? serial_out : ~last;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    word = 16'h0000;
    word_rise = 16'h0000;
    falls = 0;
  end
  task automatic start();
    falls = 0;
    cs_n = 1'b0;
    #48;
  endtask : start
  // word takes bits on falling edges; word_rise takes the first zero on
  // the first fall and every later bit on rising edges 1 to 15
  task automatic clocks(input int n);
    repeat (n) begin
      word = {word[14:0], pin};
      if (falls == 0) word_rise = {word_rise[14:0], pin};
      sclk = 1'b0;
      falls++;
      #24;
      if (falls < 16) word_rise = {word_rise[14:0], pin};
      sclk = 1'b1;
      #24;
    end
  endtask : clocks
  task automatic stop();
    cs_n = 1'b1;
    #480;
  endtask : stop
endmodule : host_model
`default_nettype wire

//--- adc_serial_readout_tb.sv
// testbench for adc_serial_readout driven by the host model
// assumes device answers link edges within about 20 ns
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_tb;
  logic        clk;
  logic        rstn;
  logic [11:0] sample_value;
  logic        cs_n;
  logic        sclk;
  logic        serial_out;
  logic        serial_oe;
  logic        hold;
  logic        powered_down;
  logic        sample_strobe;
  logic [15:0] word;
  logic [15:0] word_rise;
  int          bad_count;
  int          cmp_count;
  int          strobes;

  adc_serial_readout dut_u (
    .clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
    .sample_value(sample_value), .serial_out(serial_out),
    .serial_oe(serial_oe), .hold(hold), .powered_down(powered_down),
    .sample_strobe(sample_strobe)
  );
  host_model host_u (
    .cs_n(cs_n), .sclk(sclk), .serial_out(serial_out),
    .serial_oe(serial_oe), .word(word), .word_rise(word_rise)
  );

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (sample_strobe === 1'b1) strobes <= strobes + 1;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic normal_frame();
    host_u.start();
    chk("oe at start", 16'h1, serial_oe);
    chk("hold at start", 16'h1, hold);
    host_u.clocks(12);
    chk("hold before track", 16'h1, hold);
    host_u.clocks(1);
    chk("hold tracking", 16'h0, hold);
    host_u.clocks(3);
    chk("oe after frame", 16'h0, serial_oe);
    chk("frame word", {4'h0, sample_value}, word);
    chk("rise word", {4'h0, sample_value}, word_rise);
    host_u.stop();
  endtask : normal_frame

  // cs rises after n falls; oe must drop and power state follow the count
  task automatic abort_frame(input int n, input logic pd);
    host_u.start();
    host_u.clocks(n);
    chk("oe before abort", {15'h0, n < 16}, serial_oe);
    fork
      host_u.stop();
      begin
        #24;
        chk("oe after abort", 16'h0, serial_oe);
      end
    join
    chk("power state", {15'h0, pd}, powered_down);
  endtask : abort_frame

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    sample_value = 12'hA5C;
    bad_count = 0;
    cmp_count = 0;
    strobes = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    // link edges then land on .75 ns fractions, never on a clock edge
    #1.25;
    chk("power after reset", 16'h0, powered_down);
    normal_frame();
    chk("strobe count", 16'h1, strobes[15:0]);
    abort_frame(1, 1'b0);
    abort_frame(8, 1'b1);
    abort_frame(9, 1'b1);
    abort_frame(16, 1'b0);
    abort_frame(12, 1'b0);
    @(posedge clk);
    sample_value <= 12'h3C1;
    #1.25;
    normal_frame();
    chk("strobe total", 16'h5, strobes[15:0]);
    end_of_test();
  end

  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
endmodule : adc_serial_readout_tb
`default_nettype wire
